// >>> bench/jril_loader_assertions.sv
/*
 * jril_loader_checker: concurrent checks on the loader's ports.
 * Assumes it is bound into jril_loader and that the tap side is quiet around writes.
 */
`timescale 1ns/1ps

module jril_loader_checker (
	input wire logic                            sys_clk_in,
	input wire logic                            arst_n_in,
	input wire logic                            user_tap_reset_n_in,
	input wire logic                            test_mode_in,
	input wire logic                            falling_edge_mode_in,
	input wire logic                            load_ready_out,
	input wire logic                            overflow_out,
	input wire logic [jril_pkg::WORD_W-1:0]     mem_write_data_out,
	input wire logic [jril_pkg::ADDR_W-1:0]     mem_write_address_out,
	input wire logic [jril_pkg::NUM_BLOCKS-1:0] mem_block_select_out,
	input wire logic                            mem_clock_out,
	input wire logic                            read_enable_n_out,
	input wire logic [jril_pkg::ADDR_W-1:0]     memory_read_address_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);

	logic wr_on;
	logic norm;
	assign wr_on = |mem_block_select_out;
	assign norm  = read_enable_n_out && !falling_edge_mode_in;

	sel_shape_a: assert property ($onehot0(mem_block_select_out) || &mem_block_select_out)
		else $error("block select neither one-hot nor all");
	write_len_a: assert property ($rose(wr_on) |=> wr_on [*3] ##1 !wr_on)
		else $error("write select not held four cycles");
	clk_low_two_a: assert property ($fell(mem_clock_out) && norm
		&& $past(read_enable_n_out) |=> !mem_clock_out ##1 mem_clock_out)
		else $error("write clock low time wrong");
	data_hold_a: assert property ($rose(wr_on) |=>
		($stable(mem_write_data_out) && $stable(mem_write_address_out)) [*4])
		else $error("write data or address moved during write");
	clk_level_a: assert property ($rose(wr_on) && read_enable_n_out
		|-> mem_clock_out == falling_edge_mode_in)
		else $error("write clock polarity wrong at write start");
	rb_quiet_a: assert property (!read_enable_n_out |-> !wr_on)
		else $error("write during readback");
	rb_enable_a: assert property (!test_mode_in [*5] |-> read_enable_n_out)
		else $error("readback active without test request");
	rb_step_a: assert property (!read_enable_n_out && !$past(read_enable_n_out)
		&& $changed(memory_read_address_out)
		|-> memory_read_address_out == $past(memory_read_address_out) + 2'h1)
		else $error("read address did not step by one");
	ready_drop_a: assert property (!user_tap_reset_n_in [*3] |-> !load_ready_out)
		else $error("load ready high under tap reset");
	ovf_clear_a: assert property (!user_tap_reset_n_in [*4] |=> !overflow_out)
		else $error("overflow not cleared by tap reset");

	cover property ($rose(wr_on) && &mem_block_select_out);
	cover property ($rose(overflow_out));
	cover property ($fell(read_enable_n_out));
endmodule

bind jril_loader jril_loader_checker chk (.sys_clk_in, .arst_n_in, .user_tap_reset_n_in,
	.test_mode_in, .falling_edge_mode_in, .load_ready_out, .overflow_out,
	.mem_write_data_out, .mem_write_address_out, .mem_block_select_out, .mem_clock_out,
	.read_enable_n_out, .memory_read_address_out);

// >>> bench/jril_tap_model.sv
/*
 * jril_tap_model: behavioural user tap macro driving the loader's link side.
 * Assumes one task at a time and the sys clock on clk_in; dr clock runs only in frames.
 */
`timescale 1ns/1ps

module jril_tap_model (
	input  wire logic                      clk_in,
	output logic      [jril_pkg::IR_W-1:0] instr_out,
	output logic                           tap_rst_n_out,
	output logic                           dr_clk_out,
	output logic                           shift_out,
	output logic                           update_out,
	output logic                           sdata_out
);
	// half of the 800 ns link period, in sys clock cycles
	localparam int HALF_CYC = 4;

	initial begin
		instr_out = 8'h00;
		tap_rst_n_out = 1'b1;
		dr_clk_out = 1'b0;
		shift_out = 1'b0;
		update_out = 1'b0;
		sdata_out = 1'b0;
	end

	task automatic wait_half();
		repeat (HALF_CYC) @(posedge clk_in);
	endtask

	// instruction settles before any frame that relies on it
	task automatic load_instr(input logic [jril_pkg::IR_W-1:0] op);
		@(posedge clk_in);
		instr_out <= op;
		wait_half();
	endtask

	task automatic tap_reset();
		@(posedge clk_in);
		tap_rst_n_out <= 1'b0;
		wait_half();
		wait_half();
		tap_rst_n_out <= 1'b1;
		wait_half();
	endtask

	// lsb first; data changes only while the dr clock is low
	task automatic shift_word(input logic [jril_pkg::WORD_W-1:0] w);
		@(posedge clk_in);
		shift_out <= 1'b1;
		for (int i = 0; i < jril_pkg::WORD_W; i++) begin
			sdata_out <= w[i];
			wait_half();
			dr_clk_out <= 1'b1;
			wait_half();
			dr_clk_out <= 1'b0;
		end
		shift_out <= 1'b0;
		// released line flips so a stale bit never passes for data
		sdata_out <= ~w[jril_pkg::WORD_W-1];
		wait_half();
		update_out <= 1'b1;
		wait_half();
		update_out <= 1'b0;
		wait_half();
	endtask
endmodule

// >>> bench/tb_jril_loader.sv
/*
 * tb_jril_loader: self-checking bench for the jtag ram init loader.
 * Assumes the tap model partner and the bound checker; sys clock 10 MHz.
 */
`timescale 1ns/1ps

module tb_jril_loader;
	logic                        sys_clk = 1'b0;
	logic                        arst_n = 1'b0;
	logic                        test_mode = 1'b0;
	logic                        test_clk = 1'b0;
	logic [jril_pkg::WORD_W-1:0] read_word = '0;
	logic                        broadcast = 1'b0;
	logic                        fall_mode = 1'b0;
	logic                        mem_ready = 1'b1;
	logic [jril_pkg::IR_W-1:0]   instr;
	logic                        tap_rst_n, dr_clk, dr_shift, update_state_strobe, sdata;
	logic                        load_ready, overflow, rd_en_n, clk_out, tdo;
	logic [jril_pkg::WORD_W-1:0] wdata, tdata;
	logic [jril_pkg::ADDR_W-1:0] waddr, memory_read_address, v;
	logic [3:0]                  sel, sel_q;
	jril_pkg::jril_mem_t         exp_w;
	jril_pkg::jril_mem_t         exp_q[$];
	int                          num_errors = 0;
	int                          checked = 0;
	int                          cycles = 0;

	always #50 sys_clk = ~sys_clk;

	jril_loader dut (
		.sys_clk_in(sys_clk), .arst_n_in(arst_n), .user_instruction_value_in(instr),
		.user_tap_reset_n_in(tap_rst_n), .user_dr_clock_in(dr_clk),
		.user_dr_shift_strobe_in(dr_shift), .user_update_state_strobe_strobe_in(update_state_strobe),
		.user_serial_data_out_in(sdata), .test_mode_in(test_mode), .test_clk_in(test_clk),
		.read_word_in(read_word), .broadcast_in(broadcast), .falling_edge_mode_in(fall_mode),
		.mem_ready_in(mem_ready), .load_ready_out(load_ready), .overflow_out(overflow),
		.tap_return_data_out(tdo), .mem_write_data_out(wdata), .mem_write_address_out(waddr),
		.mem_block_select_out(sel), .mem_clock_out(clk_out), .read_enable_n_out(rd_en_n),
		.memory_read_address_out(memory_read_address), .test_data_out(tdata)
	);

	jril_tap_model tap (
		.clk_in(sys_clk), .instr_out(instr), .tap_rst_n_out(tap_rst_n), .dr_clk_out(dr_clk),
		.shift_out(dr_shift), .update_out(update_state_strobe), .sdata_out(sdata)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// expected write is noted before its word is shifted in
	task automatic send(input logic [1:0] a, input logic [3:0] s);
		logic [3:0] w;
		w = 4'($urandom);
		exp_q.push_back('{data: w, addr: a, sel: s, clk: 1'b0, rd_en_n: 1'b1});
		tap.shift_word(w);
		check(16'(tdo), 16'(w[0]));
	endtask

	task automatic drain();
		for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge sys_clk);
		check(16'(exp_q.size()), 16'h0);
		repeat (8) @(posedge sys_clk);
	endtask

	// static modes change on a clock edge, only between transfers
	task automatic set_mode(input logic b, input logic f, input logic r);
		@(posedge sys_clk);
		broadcast <= b;
		fall_mode <= f;
		mem_ready <= r;
	endtask

	always @(posedge sys_clk) begin
		sel_q <= sel;
		if (arst_n && sel_q === 4'h0 && sel !== 4'h0) begin
			exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
			check({6'h0, wdata, waddr, sel}, {6'h0, exp_w.data, exp_w.addr, exp_w.sel});
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			test_done();
		end
	end

	initial begin
		void'($urandom(32'h9524));
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		set_mode(1'b0, 1'b0, 1'b1);
		tap.load_instr(jril_pkg::OP_INIT_START);
		for (int i = 0; i < 5; i++) send(2'(i), 4'(1 << (i / 4)));
		drain();
		$display("sweep test done");
		tap.tap_reset();
		for (int b = 0; b < 4; b++) begin
			tap.load_instr(8'(jril_pkg::OP_BLOCK_BASE + b));
			send(2'(b), 4'(1 << b));
		end
		drain();
		$display("block opcode test done");
		tap.tap_reset();
		set_mode(1'b1, 1'b1, 1'b1);
		tap.load_instr(jril_pkg::OP_INIT_START);
		send(2'h0, jril_pkg::SEL_ALL);
		send(2'h1, jril_pkg::SEL_ALL);
		drain();
		set_mode(1'b0, 1'b0, 1'b1);
		v = 2'($urandom);
		tap.load_instr(jril_pkg::OP_ADDR_LOAD);
		tap.shift_word(4'(v));
		tap.load_instr(jril_pkg::OP_INIT_START);
		send(v, 4'h1);
		drain();
		$display("broadcast and address load test done");
		tap.tap_reset();
		tap.load_instr(jril_pkg::OP_READ_TEST);
		tap.shift_word(4'($urandom));
		tap.load_instr(jril_pkg::OP_INIT_START);
		set_mode(1'b0, 1'b0, 1'b0);
		send(2'h0, 4'h1);
		send(2'h1, 4'h1);
		check(16'(load_ready), 16'h0);
		tap.shift_word(4'($urandom));
		check(16'(overflow), 16'h1);
		set_mode(1'b0, 1'b0, 1'b1);
		drain();
		tap.tap_reset();
		check(16'(overflow), 16'h0);
		$display("stall and overflow test done");
		@(posedge sys_clk);
		test_mode <= 1'b1;
		tap.load_instr(jril_pkg::OP_READ_TEST);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			read_word <= 4'($urandom);
			repeat (4) @(posedge sys_clk);
			test_clk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			test_clk <= 1'b0;
			repeat (4) @(posedge sys_clk);
			@(negedge sys_clk);
			check(16'(memory_read_address), 16'(i));
			check(16'(tdata), 16'(read_word));
			check(16'(rd_en_n), 16'h0);
		end
		@(posedge sys_clk);
		test_mode <= 1'b0;
		$display("readback test done");
		test_done();
	end
endmodule

// >>> hw/jril_buffer.sv
/*
 * jril_buffer: small valid/ready fifo between word assembly and the write stage.
 * Assumes both sides run on the same clock; flush_in empties it in one edge.
 */
`timescale 1ns/1ps

module jril_buffer #(
	parameter int unsigned WIDTH = 4,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             sys_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             flush_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wptr;
		logic [PTR_W-1:0]            rptr;
		logic [PTR_W:0]              count;
	} jril_buf_state_t;

	jril_buf_state_t s_r;
	jril_buf_state_t s_nxt;
	logic            push;
	logic            pop;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready_out  = (s_r.count != (PTR_W+1)'(DEPTH));
	assign out_valid_out = (s_r.count != '0);
	assign out_data_out  = s_r.mem[s_r.rptr];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wptr] = in_data_in;
			s_nxt.wptr          = bump(s_r.wptr);
		end
		if (pop) begin
			s_nxt.rptr = bump(s_r.rptr);
		end
		s_nxt.count = s_r.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		if (flush_in) begin
			s_nxt.wptr  = '0;
			s_nxt.rptr  = '0;
			s_nxt.count = '0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

// >>> hw/jril_loader.sv
/*
 * jril_loader: loads ram blocks with words shifted in through the user tap macro,
 * and drives a read-back test. All tap side signals are sampled by sys_clk_in;
 * the data register clock must be slow enough (well under sys clock / 4) for its
 * edges to be seen. Ram blocks sit outside and take the write port signals below.
 */
`timescale 1ns/1ps

module jril_loader (
	input  wire logic                               sys_clk_in,
	input  wire logic                               arst_n_in,
	input  wire logic [jril_pkg::IR_W-1:0]          user_instruction_value_in,
	input  wire logic                               user_tap_reset_n_in,
	input  wire logic                               user_dr_clock_in,
	input  wire logic                               user_dr_shift_strobe_in,
	input  wire logic                               user_update_state_strobe_strobe_in,
	input  wire logic                               user_serial_data_out_in,
	input  wire logic                               test_mode_in,
	input  wire logic                               test_clk_in,
	input  wire logic [jril_pkg::WORD_W-1:0]        read_word_in,
	input  wire logic                               broadcast_in,
	input  wire logic                               falling_edge_mode_in,
	input  wire logic                               mem_ready_in,
	output logic                                    load_ready_out,
	output logic                                    overflow_out,
	output logic                                    tap_return_data_out,
	output logic      [jril_pkg::WORD_W-1:0]        mem_write_data_out,
	output logic      [jril_pkg::ADDR_W-1:0]        mem_write_address_out,
	output logic      [jril_pkg::NUM_BLOCKS-1:0]    mem_block_select_out,
	output logic                                    mem_clock_out,
	output logic                                    read_enable_n_out,
	output logic      [jril_pkg::ADDR_W-1:0]        memory_read_address_out,
	output logic      [jril_pkg::WORD_W-1:0]        test_data_out
);

	typedef struct packed {
		jril_pkg::jril_link_t                  sync1;
		jril_pkg::jril_link_t                  sync2;
		jril_pkg::jril_link_t                  prev;
		logic [jril_pkg::WORD_W-1:0]           shreg;
		logic [jril_pkg::ADDR_W-1:0]           addr;
		logic [jril_pkg::NUM_BLOCKS-1:0]       ring;
		logic                                  first;
		jril_pkg::jril_wstate_t                wst;
		logic [jril_pkg::CNT_W-1:0]            cnt;
		logic                                  strobe;
		jril_pkg::jril_mem_t                   mem;
		logic [jril_pkg::ADDR_W-1:0]           memory_read_address;
		logic [jril_pkg::WORD_W-1:0]           tdata;
		logic                                  ovf;
		logic                                  tdo;
	} jril_state_t;

	localparam jril_state_t STATE_RST = '{
		sync1:  jril_pkg::LINK_RST,
		sync2:  jril_pkg::LINK_RST,
		prev:   jril_pkg::LINK_RST,
		shreg:  '0,
		addr:   jril_pkg::ADDR_RST,
		ring:   jril_pkg::RING_RST,
		first:  1'b1,
		wst:    jril_pkg::JRIL_W_IDLE,
		cnt:    '0,
		strobe: 1'b0,
		mem:    jril_pkg::MEM_RST,
		memory_read_address:  jril_pkg::ADDR_RST,
		tdata:  '0,
		ovf:    1'b0,
		tdo:    1'b0
	};

	jril_state_t                   s_r;
	jril_state_t                   s_nxt;
	jril_pkg::jril_link_t          link;
	logic                          dr_rise;
	logic                          upd_rise;
	logic                          tclk_rise;
	logic                          tap_rst;
	logic                          init_en;
	logic                          addr_op;
	logic                          test_act;
	logic                          buf_in_valid;
	logic                          buf_in_ready;
	logic                          buf_out_valid;
	logic                          buf_out_ready;
	logic [jril_pkg::WORD_W-1:0]   buf_out_data;

	// one-hot select of the block whose own opcode is in the instruction register
	function automatic logic [jril_pkg::NUM_BLOCKS-1:0] block_opcode_hit(
		input logic [jril_pkg::IR_W-1:0] ir
	);
		logic [jril_pkg::NUM_BLOCKS-1:0] hit;
		hit = '0;
		for (int i = 0; i < jril_pkg::NUM_BLOCKS; i++) begin
			hit[i] = (ir == jril_pkg::OP_BLOCK_BASE + jril_pkg::IR_W'(i));
		end
		return hit;
	endfunction

	// ram clock from the strobe level, inverted unless the rams take the falling edge
	function automatic logic write_clock_of(input logic strobe, input logic fall_mode);
		return fall_mode ? strobe : ~strobe;
	endfunction

	always_comb begin
		link.instr     = user_instruction_value_in;
		link.tap_rst_n = user_tap_reset_n_in;
		link.dr_clk    = user_dr_clock_in;
		link.dr_shift  = user_dr_shift_strobe_in;
		link.update_state_strobe = user_update_state_strobe_strobe_in;
		link.sdata     = user_serial_data_out_in;
		link.test      = test_mode_in;
		link.test_clk  = test_clk_in;
		link.read_word = read_word_in;
	end

	// edges are found on the second sync stage against a delayed copy of it
	assign dr_rise   = s_r.sync2.dr_clk & ~s_r.prev.dr_clk;
	assign upd_rise  = s_r.sync2.update_state_strobe & ~s_r.prev.update_state_strobe;
	assign tclk_rise = s_r.sync2.test_clk & ~s_r.prev.test_clk;
	assign tap_rst   = ~s_r.sync2.tap_rst_n;

	// decodes use the synced instruction so all of them switch on one edge
	assign init_en  = (s_r.sync2.instr == jril_pkg::OP_INIT_START)
		| (|block_opcode_hit(s_r.sync2.instr));
	assign addr_op  = (s_r.sync2.instr == jril_pkg::OP_ADDR_LOAD);
	assign test_act = s_r.sync2.test & (s_r.sync2.instr == jril_pkg::OP_READ_TEST);

	// a completed word enters the buffer on the update strobe
	assign buf_in_valid  = upd_rise & init_en & ~tap_rst;
	// a stalled ram parks words in the buffer instead of losing them
	assign buf_out_ready = (s_r.wst == jril_pkg::JRIL_W_IDLE) & mem_ready_in & ~tap_rst;

	jril_buffer #(
		.WIDTH (jril_pkg::WORD_W),
		.DEPTH (jril_pkg::BUF_DEPTH)
	) u_word_buf (
		.sys_clk_in    (sys_clk_in),
		.arst_n_in     (arst_n_in),
		.flush_in      (tap_rst),
		.in_valid_in   (buf_in_valid),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (s_r.shreg),
		.out_valid_out (buf_out_valid),
		.out_ready_in  (buf_out_ready),
		.out_data_out  (buf_out_data)
	);

	always_comb begin
		logic [jril_pkg::ADDR_W-1:0]     addr_next;
		logic [jril_pkg::NUM_BLOCKS-1:0] ring_next;
		logic [jril_pkg::NUM_BLOCKS-1:0] sel_next;
		addr_next = '0;
		ring_next = '0;
		sel_next  = '0;
		s_nxt       = s_r;
		// every tap pin passes two flops; the macro runs on its own clock
		s_nxt.sync1 = link;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;

		// serial word assembly, lsb first, new bit enters at the top
		if (dr_rise && s_r.sync2.dr_shift) begin
			s_nxt.shreg = {s_r.sync2.sdata, s_r.shreg[jril_pkg::WORD_W-1:1]};
		end
		s_nxt.tdo = s_r.shreg[0];

		// address imported through the tap instead of the sweep
		if (upd_rise && addr_op) begin
			s_nxt.addr  = s_r.shreg[jril_pkg::ADDR_W-1:0] - 1'b1;
			s_nxt.first = 1'b1;
		end

		// write stage: strobe high for setup, low for hold, then idle
		unique case (s_r.wst)
			jril_pkg::JRIL_W_IDLE: begin
				if (buf_out_valid && buf_out_ready) begin
					// counter runs before the write, so a preset of all ones lands on zero
					addr_next = s_r.addr + 1'b1;
					ring_next = s_r.ring;
					if (!s_r.first && s_r.addr == jril_pkg::ADDR_LAST) begin
						ring_next = {s_r.ring[jril_pkg::NUM_BLOCKS-2:0],
							s_r.ring[jril_pkg::NUM_BLOCKS-1]};
					end
					if (broadcast_in) begin
						sel_next = jril_pkg::SEL_ALL;
					end else if (|block_opcode_hit(s_r.sync2.instr)) begin
						sel_next = block_opcode_hit(s_r.sync2.instr);
					end else begin
						sel_next = ring_next;
					end
					// counters stand still while the instruction does not match
					if (init_en) begin
						s_nxt.addr  = addr_next;
						s_nxt.ring  = ring_next;
						s_nxt.first = 1'b0;
					end
					s_nxt.mem.data = buf_out_data;
					s_nxt.mem.addr = addr_next;
					// a word whose instruction went away is dropped, never written
					s_nxt.mem.sel  = init_en ? sel_next : '0;
					s_nxt.strobe   = 1'b1;
					s_nxt.cnt      = jril_pkg::CNT_W'(jril_pkg::STROBE_HI_CYC - 1);
					s_nxt.wst      = jril_pkg::JRIL_W_SETUP;
				end
			end
			jril_pkg::JRIL_W_SETUP: begin
				if (s_r.cnt == '0) begin
					// write clock edge comes here, data and address held since setup
					s_nxt.strobe = 1'b0;
					s_nxt.cnt    = jril_pkg::CNT_W'(jril_pkg::STROBE_LO_CYC - 1);
					s_nxt.wst    = jril_pkg::JRIL_W_HOLD;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			jril_pkg::JRIL_W_HOLD: begin
				if (s_r.cnt == '0) begin
					// select drops a cycle before the next word can start
					s_nxt.mem.sel = '0;
					s_nxt.wst     = jril_pkg::JRIL_W_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.wst    = jril_pkg::JRIL_W_IDLE;
				s_nxt.strobe = 1'b0;
			end
		endcase

		// read-back test walks its own address on the test clock
		if (test_act && tclk_rise) begin
			s_nxt.memory_read_address = s_r.memory_read_address + 1'b1;
			s_nxt.tdata = s_r.sync2.read_word;
		end
		s_nxt.mem.rd_en_n = ~test_act;
		s_nxt.mem.clk     = test_act ? s_r.sync2.test_clk
			: write_clock_of(s_nxt.strobe, falling_edge_mode_in);

		// tap reset is seen two edges late and clears as a synchronous reset
		if (tap_rst) begin
			s_nxt.shreg    = '0;
			s_nxt.addr     = jril_pkg::ADDR_RST;
			s_nxt.ring     = jril_pkg::RING_RST;
			s_nxt.first    = 1'b1;
			s_nxt.wst      = jril_pkg::JRIL_W_IDLE;
			s_nxt.cnt      = '0;
			s_nxt.strobe   = 1'b0;
			s_nxt.mem.data = '0;
			s_nxt.mem.addr = jril_pkg::ADDR_RST;
			s_nxt.mem.sel  = '0;
			s_nxt.mem.clk  = write_clock_of(1'b0, falling_edge_mode_in);
			s_nxt.memory_read_address    = jril_pkg::ADDR_RST;
			s_nxt.ovf      = 1'b0;
		end
		// a word lost to a full buffer is flagged; setting beats the tap reset clear
		if (upd_rise && init_en && !buf_in_ready) begin
			s_nxt.ovf = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// the tap side cannot be stalled; it must watch this before updating again
	assign load_ready_out          = buf_in_ready & ~tap_rst;
	assign overflow_out            = s_r.ovf;
	assign tap_return_data_out     = s_r.tdo;
	assign mem_write_data_out      = s_r.mem.data;
	assign mem_write_address_out   = s_r.mem.addr;
	assign mem_block_select_out    = s_r.mem.sel;
	assign mem_clock_out           = s_r.mem.clk;
	assign read_enable_n_out       = s_r.mem.rd_en_n;
	assign memory_read_address_out = s_r.memory_read_address;
	assign test_data_out           = s_r.tdata;

endmodule

// >>> hw/jril_pkg.sv
/*
 * jril_pkg: shared constants and carrier types of the jtag ram init loader.
 * Assumes one user tap macro feeding 4-bit wide, 4-deep ram blocks, sys clock 10 MHz.
 */
package jril_pkg;

	// sizes of the loaded ram blocks, the instruction register and the word buffer
	localparam int unsigned WORD_W     = 4;
	localparam int unsigned ADDR_W     = 2;
	localparam int unsigned NUM_BLOCKS = 4;
	localparam int unsigned IR_W       = 8;
	localparam int unsigned BUF_DEPTH  = 2;

	// instruction opcodes
	localparam logic [IR_W-1:0] OP_INIT_START = 8'h22;
	localparam logic [IR_W-1:0] OP_READ_TEST  = 8'h23;
	localparam logic [IR_W-1:0] OP_ADDR_LOAD  = 8'h24;
	localparam logic [IR_W-1:0] OP_BLOCK_BASE = 8'h30;

	// values after reset, the last address of the sweep and the all-blocks select
	localparam logic [ADDR_W-1:0]     ADDR_RST  = 2'h3;
	localparam logic [ADDR_W-1:0]     ADDR_LAST = 2'h3;
	localparam logic [NUM_BLOCKS-1:0] RING_RST  = 4'h1;
	localparam logic [NUM_BLOCKS-1:0] SEL_ALL   = 4'hF;

	// write strobe timing
	localparam int unsigned SYS_CLK_NS    = 100;
	localparam int unsigned STROBE_HI_NS  = 200;
	localparam int unsigned STROBE_LO_NS  = 200;
	localparam int unsigned STROBE_HI_CYC = (STROBE_HI_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int unsigned STROBE_LO_CYC = (STROBE_LO_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int unsigned CNT_W         = 4;

	typedef enum logic [2:0] {
		JRIL_W_IDLE  = 3'h1,
		JRIL_W_SETUP = 3'h2,
		JRIL_W_HOLD  = 3'h4
	} jril_wstate_t;

	// everything that arrives from the tap macro side and the test bench side
	typedef struct packed {
		logic [IR_W-1:0]   instr;
		logic              tap_rst_n;
		logic              dr_clk;
		logic              dr_shift;
		logic              update_state_strobe;
		logic              sdata;
		logic              test;
		logic              test_clk;
		logic [WORD_W-1:0] read_word;
	} jril_link_t;

	localparam jril_link_t LINK_RST = '0;

	// what the loader presents to the ram blocks
	typedef struct packed {
		logic [WORD_W-1:0]     data;
		logic [ADDR_W-1:0]     addr;
		logic [NUM_BLOCKS-1:0] sel;
		logic                  clk;
		logic                  rd_en_n;
	} jril_mem_t;

	localparam jril_mem_t MEM_RST = '{data: 4'h0, addr: 2'h3, sel: 4'h0, clk: 1'b1,
		rd_en_n: 1'b1};

endpackage
